// file: design/prbs_loopback_tester.sv
// Pattern generator and checker for transceiver loopback tests.
`timescale 1ns/10ps
module prbs_loopback_tester (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [7:0]                           awaddr,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  input  wire logic [7:0]                           araddr,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  input  wire logic                                 pll_locked,
  output logic [31:0]                               tx_data,
  output logic                                      tx_valid,
  input  wire logic                                 tx_ready,
  input  wire logic [31:0]                          rx_data,
  input  wire logic                                 rx_valid,
  output logic [15:0]                               tx_lane_en,
  output logic [1:0]                                port_sel,
  output logic                                      serial_loopback,
  output prbs_tester_pkg::phy_analog_settings_t     phy_analog_settings
);
  // Words are sent MSB first, so bits [30:0] of a word are the LFSR state.
  function automatic logic [31:0] prbs_word(logic [30:0] s, logic [2:0] p);
    logic [31:0] w;
    logic [30:0] st;
    logic        b;
    int          n;
    int          m;
    w = 32'h0;
    st = s;
    case (p)
      prbs_tester_pkg::PAT_PRBS7:  begin n = 7;  m = 6;  end
      prbs_tester_pkg::PAT_PRBS15: begin n = 15; m = 14; end
      prbs_tester_pkg::PAT_PRBS23: begin n = 23; m = 18; end
      default:                     begin n = 31; m = 28; end
    endcase
    for (int i = 0; i < 32; i++) begin
      b = st[n-1] ^ st[m-1];
      st = {st[29:0], b};
      w = {w[30:0], b};
    end
    return w;
  endfunction : prbs_word

  function automatic logic [31:0] low_freq_word(logic [5:0] ph);
    logic [31:0] w;
    logic [5:0]  p;
    w = 32'h0;
    p = ph;
    for (int i = 31; i >= 0; i--) begin
      w[i] = (p < prbs_tester_pkg::LOW_FREQ_HIGH);
      p = (p == prbs_tester_pkg::LOW_FREQ_PERIOD - 6'h01) ? 6'h00 : p + 6'h01;
    end
    return w;
  endfunction : low_freq_word

  // The low-frequency stream repeats every 33 bits, so the next word is the
  // previous one shifted by a bit, topped with the last bit of the one before.
  function automatic logic [31:0] expect_word(logic [31:0] prev, logic lsb,
                                              logic [2:0] pat);
    case (pat)
      prbs_tester_pkg::PAT_HIGH_FREQ: return prev;
      prbs_tester_pkg::PAT_LOW_FREQ:  return {lsb, prev[31:1]};
      default:                        return prbs_word(prev[30:0], pat);
    endcase
  endfunction : expect_word

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] strb, logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r & msk;
  endfunction : merge

  // Register bus group.
  logic        aw_have, next_aw_have, w_have, next_w_have;
  logic [7:0]  awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0]  wstrb_q, next_wstrb_q;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, cfg, next_cfg, ana, next_ana;
  logic [15:0] next_lanes;
  logic        do_write, cmd_wr, cmd_start, cmd_stop, cmd_clear, cmd_insert;
  // Run and generator group.
  prbs_tester_pkg::run_state_t state, next_state;
  logic [31:0] gen_word, next_gen_word, next_tx_data, word;
  logic [5:0]  low_phase, next_low_phase;
  logic        ins_pend, next_ins_pend, next_tx_valid, load;
  logic [31:0] ins_cnt, next_ins_cnt, tx_cnt, next_tx_cnt;
  logic [31:0] cyc_cnt, next_cyc_cnt;
  // Checker group.
  logic [31:0] chk_prev, next_chk_prev, det_cnt, next_det_cnt;
  logic [31:0] rx_cnt, next_rx_cnt, rx_word, exp_word;
  logic        chk_lsb, next_chk_lsb, sync, next_sync, rx_take, rx_ok;
  logic [2:0]  good_cnt, next_good_cnt, bad_cnt, next_bad_cnt;
  logic        lock_meta, lock_sync;
  logic [2:0]  pat;
  logic        running;

  assign pat = cfg[prbs_tester_pkg::CFG_PAT_LSB +: 3];
  assign running = (state == prbs_tester_pkg::ST_RUN);
  assign port_sel = cfg[prbs_tester_pkg::CFG_PORT_LSB +: 2];
  assign serial_loopback = cfg[prbs_tester_pkg::CFG_LOOP_BIT];
  assign phy_analog_settings = ana[26:0];

  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_cfg = cfg;
    next_ana = ana;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_awaddr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_wdata_q = wdata;
      next_wstrb_q = wstrb;
    end
    do_write = aw_have && w_have && !bvalid;
    cmd_wr = do_write && (awaddr_q == prbs_tester_pkg::OFS_CTRL) && wstrb_q[0];
    cmd_start = cmd_wr && wdata_q[prbs_tester_pkg::CMD_START];
    cmd_stop = cmd_wr && wdata_q[prbs_tester_pkg::CMD_STOP];
    cmd_clear = cmd_wr && wdata_q[prbs_tester_pkg::CMD_CLEAR];
    cmd_insert = cmd_wr && wdata_q[prbs_tester_pkg::CMD_INSERT];
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = prbs_tester_pkg::RESP_OKAY;
      case (awaddr_q)
        prbs_tester_pkg::OFS_CTRL: ;
        prbs_tester_pkg::OFS_CFG:
          next_cfg = merge(cfg, wdata_q, wstrb_q, prbs_tester_pkg::CFG_MASK);
        prbs_tester_pkg::OFS_ANALOG:
          next_ana = merge(ana, wdata_q, wstrb_q, prbs_tester_pkg::ANA_MASK);
        default: next_bresp = prbs_tester_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    // Keep address and data closed while a write response waits to be taken.
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = prbs_tester_pkg::RESP_OKAY;
      next_rdata = 32'h0;
      case (araddr)
        prbs_tester_pkg::OFS_CTRL:     next_rdata = 32'h0;
        prbs_tester_pkg::OFS_CFG:      next_rdata = cfg;
        prbs_tester_pkg::OFS_STATUS: begin
          next_rdata[prbs_tester_pkg::ST_RUN_BIT] = running;
          next_rdata[prbs_tester_pkg::ST_SYNC_BIT] = sync;
          next_rdata[prbs_tester_pkg::ST_LOCK_BIT] = lock_sync;
        end
        prbs_tester_pkg::OFS_DET_ERR:  next_rdata = det_cnt;
        prbs_tester_pkg::OFS_INS_ERR:  next_rdata = ins_cnt;
        prbs_tester_pkg::OFS_TX_WORDS: next_rdata = tx_cnt;
        prbs_tester_pkg::OFS_RX_WORDS: next_rdata = rx_cnt;
        prbs_tester_pkg::OFS_CYCLES:   next_rdata = cyc_cnt;
        prbs_tester_pkg::OFS_ANALOG:   next_rdata = ana;
        default: next_rresp = prbs_tester_pkg::RESP_SLVERR;
      endcase
    end
    case (next_cfg[prbs_tester_pkg::CFG_PORT_LSB +: 2])
      prbs_tester_pkg::PORT_OPTIC0: next_lanes = prbs_tester_pkg::LANES_X4;
      prbs_tester_pkg::PORT_OPTIC1: next_lanes = prbs_tester_pkg::LANES_X4;
      prbs_tester_pkg::PORT_PCIE:   next_lanes = prbs_tester_pkg::LANES_X16;
      default:                      next_lanes = prbs_tester_pkg::LANES_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= prbs_tester_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= prbs_tester_pkg::RESP_OKAY;
      rdata <= 32'h0;
      cfg <= prbs_tester_pkg::CFG_RESET;
      ana <= prbs_tester_pkg::ANA_RESET;
      tx_lane_en <= prbs_tester_pkg::LANES_X4;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= (arready || rvalid) ? next_arready : 1'b1;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      cfg <= next_cfg;
      ana <= next_ana;
      tx_lane_en <= next_lanes;
    end
  end

  // Stop wins over a start written in the same word.
  always_comb begin
    next_state = state;
    if (cmd_stop) next_state = prbs_tester_pkg::ST_IDLE;
    else if (cmd_start) next_state = prbs_tester_pkg::ST_RUN;
    next_gen_word = gen_word;
    next_low_phase = low_phase;
    next_tx_data = tx_data;
    next_ins_pend = ins_pend;
    next_ins_cnt = cmd_clear ? 32'h0 : ins_cnt;
    next_tx_cnt = tx_cnt;
    next_cyc_cnt = cyc_cnt;
    load = running && (!tx_valid || tx_ready);
    case (pat)
      prbs_tester_pkg::PAT_HIGH_FREQ:
        word = prbs_tester_pkg::HIGH_FREQ_WORD;
      prbs_tester_pkg::PAT_LOW_FREQ: word = low_freq_word(low_phase);
      default: word = prbs_word(gen_word[30:0], pat);
    endcase
    if (running) next_cyc_cnt = cyc_cnt + 32'h1;
    if (tx_valid && tx_ready) next_tx_cnt = tx_cnt + 32'h1;
    if (load) begin
      next_gen_word = word;
      next_low_phase = (low_phase == 6'h00) ?
                       prbs_tester_pkg::LOW_FREQ_PERIOD - 6'h01 :
                       low_phase - 6'h01;
      next_tx_data = word ^ {31'h0, ins_pend};
      if (ins_pend) begin
        next_ins_pend = 1'b0;
        next_ins_cnt = next_ins_cnt + 32'h1;
      end
    end
    if (cmd_insert && running) next_ins_pend = 1'b1;
    if (!running) next_ins_pend = 1'b0;
    if (cmd_start) begin
      next_gen_word = {1'b0, prbs_tester_pkg::PRBS_SEED};
      next_low_phase = 6'h00;
      next_tx_cnt = 32'h0;
      next_cyc_cnt = 32'h0;
    end
    next_tx_valid = running;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= prbs_tester_pkg::ST_IDLE;
      gen_word <= {1'b0, prbs_tester_pkg::PRBS_SEED};
      low_phase <= 6'h00;
      tx_data <= 32'h0;
      tx_valid <= 1'b0;
      ins_pend <= 1'b0;
      ins_cnt <= 32'h0;
      tx_cnt <= 32'h0;
      cyc_cnt <= 32'h0;
    end else begin
      state <= next_state;
      gen_word <= next_gen_word;
      low_phase <= next_low_phase;
      tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;
      ins_pend <= next_ins_pend;
      ins_cnt <= next_ins_cnt;
      tx_cnt <= next_tx_cnt;
      cyc_cnt <= next_cyc_cnt;
    end
  end

  // Once in sync the checker follows its own prediction, so a single bad
  // word costs one count instead of poisoning the next seed as well.
  always_comb begin
    rx_word = serial_loopback ? tx_data : rx_data;
    rx_ok = serial_loopback ? (tx_valid && tx_ready) : rx_valid;
    rx_take = running && rx_ok;
    exp_word = expect_word(chk_prev, chk_lsb, pat);
    next_chk_prev = chk_prev;
    next_chk_lsb = chk_lsb;
    next_sync = sync;
    next_good_cnt = good_cnt;
    next_bad_cnt = bad_cnt;
    next_det_cnt = cmd_clear ? 32'h0 : det_cnt;
    next_rx_cnt = rx_cnt;
    if (rx_take) begin
      next_rx_cnt = rx_cnt + 32'h1;
      next_chk_lsb = chk_prev[0];
      if (sync) begin
        next_chk_prev = exp_word;
        if (rx_word != exp_word) begin
          next_det_cnt = next_det_cnt + 32'h1;
          next_bad_cnt = bad_cnt + 3'h1;
          if (next_bad_cnt == prbs_tester_pkg::SYNC_BAD) next_sync = 1'b0;
        end else begin
          next_bad_cnt = 3'h0;
        end
      end else begin
        next_chk_prev = rx_word;
        next_bad_cnt = 3'h0;
        next_good_cnt = (rx_word == exp_word) ? good_cnt + 3'h1 : 3'h0;
        if (next_good_cnt == prbs_tester_pkg::SYNC_GOOD) begin
          next_sync = 1'b1;
          next_good_cnt = 3'h0;
        end
      end
    end
    if (cmd_start) begin
      next_sync = 1'b0;
      next_good_cnt = 3'h0;
      next_bad_cnt = 3'h0;
      next_rx_cnt = 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_prev <= 32'h0;
      chk_lsb <= 1'b0;
      sync <= 1'b0;
      good_cnt <= 3'h0;
      bad_cnt <= 3'h0;
      det_cnt <= 32'h0;
      rx_cnt <= 32'h0;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      chk_prev <= next_chk_prev;
      chk_lsb <= next_chk_lsb;
      sync <= next_sync;
      good_cnt <= next_good_cnt;
      bad_cnt <= next_bad_cnt;
      det_cnt <= next_det_cnt;
      rx_cnt <= next_rx_cnt;
      lock_meta <= pll_locked;
      lock_sync <= lock_meta;
    end
  end
endmodule : prbs_loopback_tester

// file: design/prbs_tester_pkg.sv
// Constants and types shared by the loopback pattern tester.
package prbs_tester_pkg;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_DET_ERR  = 8'h0c;
  localparam logic [7:0] OFS_INS_ERR  = 8'h10;
  localparam logic [7:0] OFS_TX_WORDS = 8'h14;
  localparam logic [7:0] OFS_RX_WORDS = 8'h18;
  localparam logic [7:0] OFS_CYCLES   = 8'h1c;
  localparam logic [7:0] OFS_ANALOG   = 8'h20;
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_CLEAR  = 2;
  localparam int CMD_INSERT = 3;
  localparam int CFG_PAT_LSB  = 0;
  localparam int CFG_PORT_LSB = 4;
  localparam int CFG_LOOP_BIT = 8;
  localparam int ST_RUN_BIT   = 0;
  localparam int ST_SYNC_BIT  = 1;
  localparam int ST_LOCK_BIT  = 2;
  localparam logic [31:0] CFG_MASK  = 32'h0000_0137;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] ANA_MASK  = 32'h07ff_ffff;
  localparam logic [31:0] ANA_RESET = 32'h0000_0000;
  localparam logic [2:0] PAT_PRBS7      = 3'h0;
  localparam logic [2:0] PAT_PRBS15     = 3'h1;
  localparam logic [2:0] PAT_PRBS23     = 3'h2;
  localparam logic [2:0] PAT_PRBS31     = 3'h3;
  localparam logic [2:0] PAT_HIGH_FREQ  = 3'h4;
  localparam logic [2:0] PAT_LOW_FREQ   = 3'h5;
  localparam logic [1:0] PORT_OPTIC0 = 2'h0;
  localparam logic [1:0] PORT_OPTIC1 = 2'h1;
  localparam logic [1:0] PORT_PCIE   = 2'h2;
  localparam logic [15:0] LANES_X4  = 16'h000f;
  localparam logic [15:0] LANES_X16 = 16'hffff;
  localparam logic [15:0] LANES_OFF = 16'h0000;
  localparam logic [31:0] HIGH_FREQ_WORD = 32'haaaa_aaaa;
  localparam logic [30:0] PRBS_SEED      = 31'h7fff_ffff;
  localparam logic [5:0] LOW_FREQ_PERIOD = 6'h21;
  localparam logic [5:0] LOW_FREQ_HIGH   = 6'h11;
  localparam logic [2:0] SYNC_GOOD = 3'h2;
  localparam logic [2:0] SYNC_BAD  = 3'h4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_RUN} run_state_t;
  typedef struct packed {
    logic [3:0] vga_gain;
    logic [3:0] ac_gain;
    logic [3:0] eq_gain;
    logic [4:0] post_tap;
    logic [4:0] pre_tap;
    logic [4:0] tx_output_swing;
  } phy_analog_settings_t;
endpackage : prbs_tester_pkg

// file: verif/loopback_lane_model.sv
// Transceiver lanes looped back onto their own receivers.
`timescale 1ns/10ps
module loopback_lane_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        stall,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [31:0]      rx_data,
  output logic             rx_valid
);
  // Idle receive data is inverted every cycle so it cannot match by luck.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 32'h0;
    end else begin
      tx_ready <= !stall;
      rx_valid <= tx_valid && tx_ready;
      rx_data  <= (tx_valid && tx_ready) ? tx_data : ~rx_data;
    end
  end
endmodule : loopback_lane_model

// file: verif/prbs_loopback_tester_bench.sv
// Self-checking bench for the loopback pattern tester.
`timescale 1ns/10ps
module prbs_loopback_tester_bench;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        pll_locked = 1, stall = 0, stall_mode = 0;
  logic        awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
  logic        rx_valid, serial_loopback;
  logic [1:0]  bresp, rresp, port_sel, r;
  logic [31:0] rdata, tx_data, rx_data, d, d2;
  logic [15:0] tx_lane_en;
  prbs_tester_pkg::phy_analog_settings_t phy_analog_settings;
  int          failures = 0;
  int          num_checks = 0;
  logic [31:0] tx_q[$];
  typedef struct {
    logic [2:0] pat;
    logic loop;
    logic slow;
    int kind;
    int n;
    int k;
  } row_t;
  row_t rows[6] = '{'{prbs_tester_pkg::PAT_PRBS7, 1, 0, 0, 7, 6},
    '{prbs_tester_pkg::PAT_PRBS15, 0, 1, 0, 15, 14},
    '{prbs_tester_pkg::PAT_PRBS23, 1, 1, 0, 23, 18},
    '{prbs_tester_pkg::PAT_PRBS31, 0, 0, 0, 31, 28},
    '{prbs_tester_pkg::PAT_HIGH_FREQ, 1, 0, 1, 0, 0},
    '{prbs_tester_pkg::PAT_LOW_FREQ, 0, 1, 2, 0, 0}};
  always #25 aclk = ~aclk;
  always @(posedge aclk) stall <= stall_mode && !stall;
  always @(posedge aclk) if (tx_valid && tx_ready) tx_q.push_back(tx_data);
  prbs_loopback_tester u_prbs_loopback_tester (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pll_locked(pll_locked), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_lane_en(tx_lane_en), .port_sel(port_sel),
    .serial_loopback(serial_loopback),
    .phy_analog_settings(phy_analog_settings));
  loopback_lane_model u_loopback_lane_model (.aclk(aclk),
    .aresetn(aresetn), .stall(stall), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid));
  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic cmd(input int bitn);
    wr(prbs_tester_pkg::OFS_CTRL, 32'h1 << bitn);
  endtask : cmd
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    rd(a);
    chk(what, exp, d);
  endtask : rchk
  task automatic run(input logic [31:0] cfg);
    wr(prbs_tester_pkg::OFS_CFG, cfg);
    cmd(prbs_tester_pkg::CMD_CLEAR);
    tx_q.delete();
    cmd(prbs_tester_pkg::CMD_START);
    repeat (20) @(posedge aclk);
  endtask : run
  // Stream bits are numbered from the first word's MSB onwards.
  function automatic int bad_bits(input row_t w, input logic [63:0] s);
    int b;
    b = 0;
    for (int t = 0; t < 64; t++) begin
      case (w.kind)
        0: if (t >= 32 && s[63-t] !== (s[63-t+w.n] ^ s[63-t+w.k])) b++;
        1: if (s[63-t] !== (t % 2 == 0)) b++;
        default: if (s[63-t] !== (t % 33 < 17)) b++;
      endcase
    end
    return b;
  endfunction : bad_bits
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      stall_mode <= rows[i].slow;
      run({23'h0, rows[i].loop, 5'h0, rows[i].pat});
      chk("pattern", 0, 32'(bad_bits(rows[i], {tx_q[0], tx_q[1]})));
      rchk("status", prbs_tester_pkg::OFS_STATUS, 32'h7);
      rchk("detected", prbs_tester_pkg::OFS_DET_ERR, 0);
      cmd(prbs_tester_pkg::CMD_STOP);
      $display("row %0d done", i);
    end
    stall_mode <= 1'b0;
    cmd(prbs_tester_pkg::CMD_INSERT);
    rchk("idle insert", prbs_tester_pkg::OFS_INS_ERR, 0);
    run(32'h100);
    cmd(prbs_tester_pkg::CMD_INSERT);
    repeat (10) @(posedge aclk);
    rchk("inserted", prbs_tester_pkg::OFS_INS_ERR, 1);
    rchk("detected", prbs_tester_pkg::OFS_DET_ERR, 1);
    cmd(prbs_tester_pkg::CMD_STOP);
    repeat (2) @(posedge aclk);
    chk("tx valid", 0, {31'h0, tx_valid});
    rd(prbs_tester_pkg::OFS_TX_WORDS);
    d2 = d;
    rchk("tx words", prbs_tester_pkg::OFS_TX_WORDS, d2);
    rchk("cycles", prbs_tester_pkg::OFS_CYCLES, d2);
    // The word that leaves in the cycle after stop is sent but not checked.
    rchk("rx words", prbs_tester_pkg::OFS_RX_WORDS, d2 - 32'h1);
    cmd(prbs_tester_pkg::CMD_CLEAR);
    rchk("cleared det", prbs_tester_pkg::OFS_DET_ERR, 0);
    rchk("cleared ins", prbs_tester_pkg::OFS_INS_ERR, 0);
    $display("insert and clear done");
    wr(prbs_tester_pkg::OFS_ANALOG, 32'hffff_ffea);
    chk("analog out", 32'h07ff_ffea, {5'h0, phy_analog_settings});
    rchk("analog", prbs_tester_pkg::OFS_ANALOG, 32'h07ff_ffea);
    wr(prbs_tester_pkg::OFS_CFG, 32'h20);
    chk("lanes", {16'h0, prbs_tester_pkg::LANES_X16}, {16'h0, tx_lane_en});
    wr(prbs_tester_pkg::OFS_CFG, 32'h30);
    chk("lanes off", {16'h0, prbs_tester_pkg::LANES_OFF}, {16'h0, tx_lane_en});
    wr(prbs_tester_pkg::OFS_STATUS, 32'h0);
    chk("ro write", {30'h0, prbs_tester_pkg::RESP_SLVERR}, {30'h0, r});
    rd(8'h24);
    chk("unmapped", {30'h0, prbs_tester_pkg::RESP_SLVERR}, {30'h0, r});
    pll_locked <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(prbs_tester_pkg::OFS_STATUS);
    chk("lock", 0, {31'h0, d[prbs_tester_pkg::ST_LOCK_BIT]});
    $display("register cases done");
    pll_locked <= 1'b1;
    run(32'h110);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset tx", 0, {31'h0, tx_valid});
    chk("reset lanes", 32'h000f, {16'h0, tx_lane_en});
    rchk("reset cfg", prbs_tester_pkg::OFS_CFG, prbs_tester_pkg::CFG_RESET);
    rchk("reset analog", prbs_tester_pkg::OFS_ANALOG, 0);
    $display("reset case done");
    tally_and_finish();
  end
endmodule : prbs_loopback_tester_bench

// file: verif/prbs_tester_sva.sv
// Bus and stream checks for the loopback pattern tester.
`timescale 1ns/10ps
module prbs_tester_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [15:0] tx_lane_en,
  input wire logic [1:0]  port_sel
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_answer;
    !awready ##[0:1] bvalid;
  endsequence
  a_write_resp: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response missing");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_rdata_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read accepted while busy");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while busy");
  a_unmapped_rd: assert property (arvalid && arready &&
    araddr > prbs_tester_pkg::OFS_ANALOG |=>
    rresp == prbs_tester_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read answered");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    !tx_valid || $stable(tx_data))
    else $error("tx word changed before taken");
  a_lane_pcie: assert property ($stable(port_sel) &&
    port_sel == prbs_tester_pkg::PORT_PCIE |->
    tx_lane_en == prbs_tester_pkg::LANES_X16)
    else $error("wide port lanes wrong");
  a_lane_optic: assert property ($stable(port_sel) && port_sel < 2'h2 |->
    tx_lane_en == prbs_tester_pkg::LANES_X4)
    else $error("optic port lanes wrong");
endmodule : prbs_tester_sva
bind prbs_loopback_tester prbs_tester_sva u_prbs_tester_sva (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_lane_en(tx_lane_en), .port_sel(port_sel));
